// *** uart_chan_consts.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the channel
// Assumes: 100 MHz pclk; baud ticks arrive as one-cycle pulses on pclk
// Notes:   shared by the channel module, its assertions and the bench
//
// How it works
// - second mode register is reached only while the pointer selects it; its access keeps pointer
// - channel mode field: 00 normal, 01 echo, 10 local loop, 11 remote loop
// - echo mode reclocks received line on receive clock and sends it out
// - echo mode forces tx room and tx empty status low, ignores host tx writes
// - echo mode checks parity and framing, retransmits parity and stop as received
// - echo and remote loop echo a break until next valid start bit
// - local loop feeds transmitter output to receiver, receiver timed by transmit clock
// - local loop holds serial output high and ignores serial input
// - remote loop retransmits received data, delivers nothing to host, errors stay inactive
// - remote loop skips parity and framing checks, retransmits bits as received
// - mode changes take effect at once, even mid character
// - leaving echo after stop sample with transmitter enabled keeps echo until stop resent
// - request-to-send output is low while output register bit zero is set
// - auto rts clears output bit zero one bit after all sent, transmitter disabled
// - with cts control, character waits at start until clear-to-send input is low
// - character in flight completes regardless of cts; control off ignores cts
// - stop length field in sixteenths: codes 0-7 give 9..16, 8-F give 25..32
// - five-bit characters add half a bit to stop codes 0 to 7
// - receiver checks only for mark at stop bit centre
// - with external 1X transmit clock, stop field bit 3 picks one or two stops
// - pointer goes to first mode register on reset or pointer-reset command
`ifndef UART_CHAN_CONSTS_SVH
`define UART_CHAN_CONSTS_SVH

// register byte offsets
`define OFS_MODE          8'h00
`define OFS_COMMAND       8'h04
`define OFS_STATUS        8'h08
`define OFS_DATA          8'h0C

// mode register two fields
`define MR2_MODE_HI       7
`define MR2_MODE_LO       6
`define MR2_TX_RTS        5
`define MR2_CTS_EN        4
`define MR2_STOP_HI       3
`define MR2_STOP_LO       0

// channel mode codes
`define MODE_NORMAL       2'h0
`define MODE_ECHO         2'h1
`define MODE_LOCAL        2'h2
`define MODE_REMOTE       2'h3

// mode register one fields
`define MR1_PAR_HI        4
`define MR1_PAR_LO        3
`define MR1_PAR_TYPE      2
`define MR1_LEN_HI        1
`define MR1_LEN_LO        0
`define PAR_WITH          2'h0
`define PAR_NONE          2'h2

// command register fields and miscellaneous codes
`define CMD_RX_ON         0
`define CMD_RX_OFF        1
`define CMD_TX_ON         2
`define CMD_TX_OFF        3
`define MISC_PTR_RESET    4'h1
`define MISC_ERR_RESET    4'h4
`define MISC_RTS_SET      4'h8
`define MISC_RTS_CLEAR    4'h9

// status register bit positions
`define ST_RX_CHAR        0
`define ST_TX_ROOM        2
`define ST_TX_EMPTY       3
`define ST_PAR_ERR        5
`define ST_FRM_ERR        6
`define ST_BREAK          7

// reset values
`define MR1_RESET         8'h00
`define MR2_RESET         8'h00

// timing in 16X ticks
`define TICKS_PER_BIT     6'h10
`define TICKS_HALF_BIT    5'h07
`define TICKS_BIT_LAST    5'h0F
`define STOP_BASE_SHORT   6'h09
`define STOP_BASE_LONG    6'h19
`define STOP_FIVE_EXTRA   6'h08
`define ECHO_HOLD_TICKS   5'h10

`endif

// *** uart_chan_pkg.sv ***
// Purpose: types of the serial channel
// Assumes: constants come from uart_chan_consts.svh
// Notes:   all module state is one packed struct
package uart_chan_pkg;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK} rx_state_t;

  typedef struct packed {
    logic       rx_en;
    logic       tx_en;
    logic       opr0;
    logic       ptr_second;
  } ctrl_t;

  typedef struct packed {
    logic [7:0]  mr1;
    logic [7:0]  mr2;
    ctrl_t       ctrl;
    logic        rts_low;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        rx_s1;
    logic        rx_s2;
    logic        cts_s1;
    logic        cts_s2;
    logic        txd;
    logic        tx_line;
    logic        echo_line;
    logic [4:0]  echo_hold;
    tx_state_t   tx_st;
    logic [5:0]  tx_sub;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_shift;
    logic        tx_par;
    logic [7:0]  tx_hold;
    logic        tx_hold_full;
    logic [5:0]  rts_cnt;
    rx_state_t   rx_st;
    logic [4:0]  rx_sub;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic        rx_par;
    logic [7:0]  rx_data;
    logic        rx_has_char;
    logic        par_err;
    logic        frm_err;
    logic        brk;
  } state_t;

endpackage

// *** uart_chan.sv ***
// Purpose: serial channel with channel modes, rts/cts control and stop length select
// Assumes: tx_tick and rx_tick16 are one-cycle pulses on pclk
// Notes:   one-entry transmit and receive holding registers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "uart_chan_consts.svh"

module uart_chan
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // baud timing
  input  wire logic        tx_tick,
  input  wire logic        tx_ext_1x,
  input  wire logic        rx_tick16,
  // serial pins
  input  wire logic        rx_data_in,
  output logic             tx_data_out,
  input  wire logic        clear_to_send_low,
  output logic             request_to_send_low
);

  uart_chan_pkg::state_t s;
  uart_chan_pkg::state_t n;

  logic [1:0] mode;
  logic       echo_like;
  logic       local_loop;
  logic       rx_line;
  logic       rx_tick;
  logic [2:0] data_last;
  logic [5:0] bit_last;
  logic [5:0] stop_last;
  logic       par_on;
  logic       req;
  logic       done;
  logic [3:0] misc;
  logic [7:0] aligned;
  logic       tx_go;
  logic       launch;

  always_comb
  begin
    mode       = s.mr2[`MR2_MODE_HI:`MR2_MODE_LO];
    local_loop = (mode == `MODE_LOCAL);
    echo_like  = (mode == `MODE_ECHO) || (mode == `MODE_REMOTE) || (s.echo_hold != 5'h00);
    rx_line    = local_loop ? s.tx_line : s.rx_s2;
    rx_tick    = local_loop ? tx_tick : rx_tick16;
    data_last  = {1'b1, s.mr1[`MR1_LEN_HI:`MR1_LEN_LO]};
    par_on     = (s.mr1[`MR1_PAR_HI:`MR1_PAR_LO] != `PAR_NONE);
    bit_last   = tx_ext_1x ? 6'h00 : (`TICKS_PER_BIT - 6'h01);
    if (tx_ext_1x)
    begin
      stop_last = s.mr2[`MR2_STOP_HI] ? 6'h01 : 6'h00;
    end
    else if (s.mr2[`MR2_STOP_HI])
    begin
      stop_last = `STOP_BASE_LONG + {3'h0, s.mr2[2:0]} - 6'h01;
    end
    else
    begin
      stop_last = `STOP_BASE_SHORT + {3'h0, s.mr2[2:0]} - 6'h01;
      if (s.mr1[`MR1_LEN_HI:`MR1_LEN_LO] == 2'h0)
      begin
        stop_last = stop_last + `STOP_FIVE_EXTRA;
      end
    end
    req  = psel && penable;
    done = req && s.pready;
    misc = pwdata[7:4];
    aligned = s.rx_shift >> (3'h3 - {1'b0, s.mr1[`MR1_LEN_HI:`MR1_LEN_LO]});
    tx_go   = s.tx_hold_full && !(s.mr2[`MR2_CTS_EN] && s.cts_s2);
  end

  always_comb
  begin
    n = s;
    launch = 1'b0;
    n.rx_s1  = rx_data_in;
    n.rx_s2  = s.rx_s1;
    n.cts_s1 = clear_to_send_low;
    n.cts_s2 = s.cts_s1;

    // apb: answer one cycle into the access phase, act on the completing edge
    n.pready  = req && !s.pready;
    n.pslverr = 1'b0;
    if (req && !s.pready)
    begin
      n.prdata = 32'h0000_0000;
      case (paddr)
        `OFS_MODE:
          n.prdata[7:0] = s.ctrl.ptr_second ? s.mr2 : s.mr1;
        `OFS_COMMAND:
          n.prdata[3:0] = {s.ctrl.ptr_second, s.ctrl.opr0, s.ctrl.tx_en, s.ctrl.rx_en};
        `OFS_STATUS:
        begin
          n.prdata[`ST_RX_CHAR] = s.rx_has_char;
          n.prdata[`ST_TX_ROOM] = !echo_like && s.ctrl.tx_en && !s.tx_hold_full;
          n.prdata[`ST_TX_EMPTY] = !echo_like && s.ctrl.tx_en && !s.tx_hold_full
                                   && (s.tx_st == uart_chan_pkg::TX_IDLE);
          n.prdata[`ST_PAR_ERR] = s.par_err;
          n.prdata[`ST_FRM_ERR] = s.frm_err;
          n.prdata[`ST_BREAK] = s.brk;
        end
        `OFS_DATA:
          n.prdata[7:0] = s.rx_data;
        default:
          n.pslverr = 1'b1;
      endcase
    end
    if (done && !s.pslverr)
    begin
      case (paddr)
        `OFS_MODE:
        begin
          if (pwrite && s.ctrl.ptr_second)
          begin
            n.mr2 = pwdata[7:0];
          end
          else if (pwrite)
          begin
            n.mr1 = pwdata[7:0];
          end
          n.ctrl.ptr_second = 1'b1;
        end
        `OFS_COMMAND:
        begin
          if (pwrite)
          begin
            if (pwdata[`CMD_RX_ON])
            begin
              n.ctrl.rx_en = 1'b1;
            end
            if (pwdata[`CMD_RX_OFF])
            begin
              n.ctrl.rx_en = 1'b0;
            end
            if (pwdata[`CMD_TX_ON])
            begin
              n.ctrl.tx_en = 1'b1;
            end
            if (pwdata[`CMD_TX_OFF])
            begin
              n.ctrl.tx_en = 1'b0;
            end
            case (misc)
              `MISC_PTR_RESET:
                n.ctrl.ptr_second = 1'b0;
              `MISC_ERR_RESET:
              begin
                n.par_err = 1'b0;
                n.frm_err = 1'b0;
                n.brk     = 1'b0;
              end
              `MISC_RTS_CLEAR:
                n.ctrl.opr0 = 1'b0;
              default:
                n.ctrl.opr0 = s.ctrl.opr0;
            endcase
          end
        end
        `OFS_DATA:
        begin
          if (pwrite && s.ctrl.tx_en && !s.tx_hold_full && !echo_like)
          begin
            n.tx_hold      = pwdata[7:0];
            n.tx_hold_full = 1'b1;
          end
          else if (!pwrite)
          begin
            n.rx_has_char = 1'b0;
          end
        end
        default:
          n.pslverr = 1'b0;
      endcase
    end

    // echo path: received line reclocked on the receive clock
    if (rx_tick16)
    begin
      n.echo_line = s.rx_s2;
      if (s.echo_hold != 5'h00)
      begin
        n.echo_hold = s.echo_hold - 5'h01;
      end
    end

    // receiver, sampling at the bit centre
    if (!s.ctrl.rx_en)
    begin
      n.rx_st = uart_chan_pkg::RX_IDLE;
    end
    else if (rx_tick)
    begin
      n.rx_sub = s.rx_sub + 5'h01;
      case (s.rx_st)
        uart_chan_pkg::RX_IDLE:
        begin
          n.rx_sub = 5'h00;
          if (!rx_line)
          begin
            n.rx_st = uart_chan_pkg::RX_START;
          end
        end
        uart_chan_pkg::RX_START:
        begin
          if (s.rx_sub == `TICKS_HALF_BIT)
          begin
            n.rx_sub = 5'h00;
            n.rx_bit = 3'h0;
            n.rx_st  = rx_line ? uart_chan_pkg::RX_IDLE : uart_chan_pkg::RX_DATA;
          end
        end
        uart_chan_pkg::RX_DATA:
        begin
          if (s.rx_sub == `TICKS_BIT_LAST)
          begin
            n.rx_sub   = 5'h00;
            n.rx_shift = {rx_line, s.rx_shift[7:1]};
            n.rx_bit   = s.rx_bit + 3'h1;
            if (s.rx_bit == data_last)
            begin
              n.rx_st = par_on ? uart_chan_pkg::RX_PARITY : uart_chan_pkg::RX_STOP;
            end
          end
        end
        uart_chan_pkg::RX_PARITY:
        begin
          if (s.rx_sub == `TICKS_BIT_LAST)
          begin
            n.rx_sub = 5'h00;
            n.rx_par = rx_line;
            n.rx_st  = uart_chan_pkg::RX_STOP;
          end
        end
        uart_chan_pkg::RX_STOP:
        begin
          if (s.rx_sub == `TICKS_BIT_LAST)
          begin
            n.rx_sub = 5'h00;
            n.rx_st  = uart_chan_pkg::RX_IDLE;
            if (echo_like && s.ctrl.tx_en)
            begin
              n.echo_hold = `ECHO_HOLD_TICKS;
            end
            if (!rx_line && (s.rx_shift == 8'h00) && !(par_on && s.rx_par))
            begin
              n.rx_st = uart_chan_pkg::RX_BREAK;
            end
            if (mode != `MODE_REMOTE)
            begin
              n.rx_data     = aligned;
              n.rx_has_char = 1'b1;
              if (!rx_line)
              begin
                n.frm_err = 1'b1;
                n.brk     = (s.rx_shift == 8'h00) || s.brk;
              end
              if (s.mr1[`MR1_PAR_HI:`MR1_PAR_LO] == `PAR_WITH
                  && (^{aligned, s.rx_par} != s.mr1[`MR1_PAR_TYPE]))
              begin
                n.par_err = 1'b1;
              end
            end
          end
        end
        uart_chan_pkg::RX_BREAK:
        begin
          n.rx_sub = 5'h00;
          if (rx_line)
          begin
            n.rx_st = uart_chan_pkg::RX_IDLE;
          end
        end
        default:
          n.rx_st = uart_chan_pkg::RX_IDLE;
      endcase
    end

    // transmitter
    if (tx_tick)
    begin
      n.tx_sub = s.tx_sub + 6'h01;
      case (s.tx_st)
        uart_chan_pkg::TX_IDLE:
        begin
          n.tx_sub = 6'h00;
          launch   = tx_go;
        end
        uart_chan_pkg::TX_START:
        begin
          if (s.tx_sub == bit_last)
          begin
            n.tx_sub  = 6'h00;
            n.tx_line = s.tx_shift[0];
            n.tx_st   = uart_chan_pkg::TX_DATA;
          end
        end
        uart_chan_pkg::TX_DATA:
        begin
          if (s.tx_sub == bit_last)
          begin
            n.tx_sub   = 6'h00;
            n.tx_shift = {1'b0, s.tx_shift[7:1]};
            n.tx_bit   = s.tx_bit + 3'h1;
            if (s.mr1[`MR1_PAR_HI:`MR1_PAR_LO] == `PAR_WITH)
            begin
              n.tx_par = s.tx_par ^ s.tx_shift[0];
            end
            n.tx_line = s.tx_shift[1];
            if (s.tx_bit == data_last)
            begin
              n.tx_line = par_on ? n.tx_par : 1'b1;
              n.tx_st   = par_on ? uart_chan_pkg::TX_PARITY : uart_chan_pkg::TX_STOP;
            end
          end
        end
        uart_chan_pkg::TX_PARITY:
        begin
          if (s.tx_sub == bit_last)
          begin
            n.tx_sub  = 6'h00;
            n.tx_line = 1'b1;
            n.tx_st   = uart_chan_pkg::TX_STOP;
          end
        end
        uart_chan_pkg::TX_STOP:
        begin
          if (s.tx_sub == stop_last)
          begin
            n.tx_sub = 6'h00;
            n.tx_st  = uart_chan_pkg::TX_IDLE;
            // a waiting character starts here, so the stop gets no extra idle tick
            launch   = tx_go;
          end
        end
        default:
          n.tx_st = uart_chan_pkg::TX_IDLE;
      endcase
      if (launch)
      begin
        n.tx_shift     = s.tx_hold;
        n.tx_hold_full = 1'b0;
        n.tx_bit       = 3'h0;
        n.tx_par       = s.mr1[`MR1_PAR_TYPE];
        n.tx_line      = 1'b0;
        n.tx_st        = uart_chan_pkg::TX_START;
      end
    end

    // automatic request-to-send negation after the line has drained
    if (s.mr2[`MR2_TX_RTS] && s.ctrl.opr0 && !s.ctrl.tx_en && !s.tx_hold_full
        && (s.tx_st == uart_chan_pkg::TX_IDLE))
    begin
      if (tx_tick)
      begin
        n.rts_cnt = s.rts_cnt + 6'h01;
        if (s.rts_cnt == bit_last)
        begin
          n.ctrl.opr0 = 1'b0;
          n.rts_cnt   = 6'h00;
        end
      end
    end
    else
    begin
      n.rts_cnt = 6'h00;
    end
    // software set wins over the automatic clear
    if (done && pwrite && (paddr == `OFS_COMMAND) && (misc == `MISC_RTS_SET))
    begin
      n.ctrl.opr0 = 1'b1;
    end
    n.rts_low = !n.ctrl.opr0;

    if (local_loop)
    begin
      n.txd = 1'b1;
    end
    else if (echo_like)
    begin
      n.txd = n.echo_line;
    end
    else
    begin
      n.txd = n.tx_line;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s           <= '0;
      s.mr1       <= `MR1_RESET;
      s.mr2       <= `MR2_RESET;
      s.rts_low   <= 1'b1;
      s.rx_s1     <= 1'b1;
      s.rx_s2     <= 1'b1;
      s.cts_s1    <= 1'b1;
      s.cts_s2    <= 1'b1;
      s.txd       <= 1'b1;
      s.tx_line   <= 1'b1;
      s.echo_line <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign prdata              = s.prdata;
  assign pready              = s.pready;
  assign pslverr             = s.pslverr;
  assign tx_data_out         = s.txd;
  assign request_to_send_low = s.rts_low;

endmodule

// *** uart_chan_sva.sv ***
// Purpose: port assertions for the serial channel
// Assumes: pointer and channel mode are shadowed from apb traffic
// Notes:   bound to uart_chan from the bench top file
`timescale 1ns/1ps
`include "uart_chan_consts.svh"
module uart_chan_sva
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // baud timing and serial pins
  input wire logic        tx_tick,
  input wire logic        tx_ext_1x,
  input wire logic        rx_tick16,
  input wire logic        rx_data_in,
  input wire logic        tx_data_out,
  input wire logic        clear_to_send_low,
  input wire logic        request_to_send_low
);
  logic       acc;
  logic       ptr;
  logic [7:0] mr2;
  logic [3:0] loc_h;
  assign acc = psel && penable && pready;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ptr   <= 1'h0;
      mr2   <= 8'h00;
      loc_h <= 4'h0;
    end
    else
    begin
      loc_h <= {loc_h[2:0], mr2[7:6] == `MODE_LOCAL};
      if (acc && paddr == `OFS_MODE)
        ptr <= 1'h1;
      if (acc && paddr == `OFS_MODE && ptr && pwrite)
        mr2 <= pwdata[7:0];
      if (acc && pwrite && paddr == `OFS_COMMAND && pwdata[7:4] == `MISC_PTR_RESET)
        ptr <= 1'h0;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_wait_state: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood more than one cycle");
  a_unmapped_err: assert property (acc && paddr > `OFS_DATA |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mode_readback: assert property (acc && !pwrite && paddr == `OFS_MODE && ptr |-> prdata == {24'h0, mr2})
    else $error("second mode register read back wrong");
  a_rts_assert: assert property (acc && pwrite && paddr == `OFS_COMMAND &&
    pwdata[7:4] == `MISC_RTS_SET |-> ##[1:3] !request_to_send_low)
    else $error("request to send not asserted");
  a_rts_negate: assert property (acc && pwrite && paddr == `OFS_COMMAND &&
    pwdata[7:4] == `MISC_RTS_CLEAR |-> ##[1:3] request_to_send_low)
    else $error("request to send not negated");
  a_local_mark: assert property (loc_h == 4'hF |-> tx_data_out)
    else $error("serial output not marking in local loop");
  a_echo_status: assert property (acc && !pwrite && paddr == `OFS_STATUS &&
    mr2[7:6] == `MODE_ECHO |-> prdata[3:2] == 2'h0)
    else $error("transmitter status active in echo mode");
  a_remote_errs: assert property (acc && !pwrite && paddr == `OFS_STATUS &&
    mr2[7:6] == `MODE_REMOTE |-> prdata[7:5] == 3'h0)
    else $error("error status active in remote loop");
  c_mode_write: cover property (acc && pwrite && paddr == `OFS_MODE && ptr);
  c_auto_rts: cover property ($rose(request_to_send_low));
  c_remote_read: cover property (acc && paddr == `OFS_STATUS && mr2[7:6] == `MODE_REMOTE);
endmodule

// *** uart_remote_station.sv ***
// Purpose: far-end serial station sending frames and watching the returned line
// Assumes: frames are timed on the receive tick, 16 ticks per bit
// Notes:   the line is driven to mark after each frame; hold_level can hold it at either level
`timescale 1ns/1ps
module uart_remote_station
(
  // timing
  input  wire logic pclk,
  input  wire logic rx_tick16,
  // serial lines seen from the far end
  input  wire logic tx_data_out,
  output logic      rx_line
);
  logic [15:0] seen;
  initial rx_line = 1'h1;
  // sends lsb first and samples the returned line late in each bit
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
      for (int t = 0; t < 16; t++)
      begin
        @(posedge pclk iff rx_tick16);
        if (t == 0)
          rx_line <= bits[i];
        if (t == 12)
          seen[i] = tx_data_out;
      end
    rx_line <= 1'h1;
  endtask
  task automatic hold_level(input logic v);
    @(posedge pclk);
    rx_line <= v;
  endtask
  // cycles from one start edge on the returned line to the next
  task automatic gap(output int cyc);
    wait (tx_data_out === 1'h0);
    cyc = -1; // reads see the line one edge late, so the closing edge is one extra
    do
    begin
      @(posedge pclk);
      cyc++;
    end while (tx_data_out !== 1'h1);
    do
    begin
      @(posedge pclk);
      cyc++;
    end while (tx_data_out !== 1'h0);
  endtask
endmodule

// *** uart_channel_mode_flow_stop_bench.sv ***
// Purpose: self-checking bench of the channel modes, rts/cts control and stop lengths
// Assumes: baud ticks every fourth pclk
// Notes:   far end is uart_remote_station
`timescale 1ns/1ps
`include "uart_chan_consts.svh"
module uart_channel_mode_flow_stop_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        tx_tick, tx_ext_1x, rx_tick16, rx_data_in, tx_data_out;
  logic        clear_to_send_low, request_to_send_low;
  logic [1:0]  tdiv;
  int          err_count, tests_run, cycles, cyc;
  logic [7:0]  s_mr1 [8] = '{8'h13, 8'h13, 8'h13, 8'h13, 8'h10, 8'h10, 8'h13, 8'h13};
  logic [3:0]  s_code[8] = '{4'h0, 4'h7, 4'h8, 4'hF, 4'h0, 4'h8, 4'h0, 4'h8};
  logic        s_x1  [8] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
  int          s_tick[8] = '{153, 160, 169, 176, 113, 121, 10, 11};
  uart_chan i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_tick(tx_tick), .tx_ext_1x(tx_ext_1x), .rx_tick16(rx_tick16),
    .rx_data_in(rx_data_in), .tx_data_out(tx_data_out),
    .clear_to_send_low(clear_to_send_low), .request_to_send_low(request_to_send_low));
  uart_remote_station i_far (.pclk(pclk), .rx_tick16(rx_tick16),
    .tx_data_out(tx_data_out), .rx_line(rx_data_in));
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    tdiv <= tdiv + 2'h1;
    tx_tick <= (tdiv == 2'h3);
    rx_tick16 <= (tdiv == 2'h1);
    cycles++;
    if (cycles == 60000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    tests_run++;
    if (seen !== want)
    begin
      err_count++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {rerr, rdat} = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wait_st(input int b);
    for (int n = 0; n < 400 && rdat[b] !== 1'h1; n++)
      apb(1'h0, `OFS_STATUS, 8'h00);
  endtask
  task automatic set_mode(input logic [7:0] m1, input logic [7:0] m2);
    apb(1'h1, `OFS_COMMAND, 8'h10);
    apb(1'h1, `OFS_MODE, m1);
    apb(1'h1, `OFS_MODE, m2);
  endtask
  task automatic test_regs();
    apb(1'h0, `OFS_MODE, 8'h00);
    check(rdat, 32'h0, "first mode reset");
    apb(1'h0, `OFS_MODE, 8'h00);
    check(rdat, 32'h0, "second mode reset");
    apb(1'h1, `OFS_MODE, 8'h37);
    apb(1'h0, `OFS_MODE, 8'h00);
    check(rdat, 32'h37, "second mode kept");
    apb(1'h1, `OFS_COMMAND, 8'h10);
    apb(1'h0, `OFS_MODE, 8'h00);
    check(rdat, 32'h0, "pointer back to first");
    apb(1'h1, `OFS_COMMAND, 8'h80);
    apb(1'h1, `OFS_COMMAND, 8'h90);
    check(request_to_send_low, 1'h1, "rts negated");
    apb(1'h0, 8'h10, 8'h00);
    check(rerr, 1'h1, "unmapped refused");
    check(pslverr, 1'h0, "error pulse gone");
  endtask
  task automatic test_stop();
    for (int i = 0; i < 8; i++)
    begin
      set_mode(s_mr1[i], {4'h0, s_code[i]});
      tx_ext_1x <= s_x1[i];
      fork
        i_far.gap(cyc);
        begin
          apb(1'h1, `OFS_COMMAND, 8'h04);
          apb(1'h1, `OFS_DATA, 8'hFF);
          rdat = 32'h0;
          wait_st(`ST_TX_ROOM);
          apb(1'h1, `OFS_DATA, 8'hFF);
        end
      join
      check(cyc, s_tick[i] * 4, "frame length");
      rdat = 32'h0;
      wait_st(`ST_TX_EMPTY);
      apb(1'h1, `OFS_COMMAND, 8'h08);
    end
    tx_ext_1x <= 1'h0;
  endtask
  task automatic test_echo();
    for (int m = 1; m < 4; m += 2)
    begin
      set_mode(8'h03, {m[1:0], 6'h07});
      apb(1'h1, `OFS_COMMAND, 8'h41);
      i_far.send(16'h06B4, 11);
      check(i_far.seen[10:0], 11'h6B4, "echoed frame");
      apb(1'h0, `OFS_STATUS, 8'h00);
      check(rdat & 32'hED, (m == 1) ? 32'h21 : 32'h0, "echo status");
      apb(1'h0, `OFS_DATA, 8'h00);
      if (m == 1)
        check(rdat, 32'h5A, "echo char to host");
      repeat (100) @(posedge pclk);
    end
  endtask
  task automatic test_local();
    set_mode(8'h13, 8'h87);
    i_far.hold_level(1'h0);
    apb(1'h1, `OFS_COMMAND, 8'h45);
    apb(1'h1, `OFS_DATA, 8'hA5);
    rdat = 32'h0;
    wait_st(`ST_RX_CHAR);
    apb(1'h0, `OFS_DATA, 8'h00);
    check(rdat, 32'hA5, "local loop char");
    i_far.hold_level(1'h1);
    apb(1'h1, `OFS_COMMAND, 8'h0A);
  endtask
  task automatic test_cts();
    logic quiet;
    set_mode(8'h13, 8'h17);
    clear_to_send_low <= 1'h1;
    apb(1'h1, `OFS_COMMAND, 8'h04);
    apb(1'h1, `OFS_DATA, 8'h00);
    quiet = 1'h1;
    repeat (300) @(posedge pclk) quiet &= tx_data_out;
    check(quiet, 1'h1, "held marking");
    clear_to_send_low <= 1'h0;
    for (int n = 0; n < 20 && tx_data_out !== 1'h0; n++)
      @(posedge pclk);
    check(tx_data_out, 1'h0, "start after clear");
    clear_to_send_low <= 1'h1;
    rdat = 32'h0;
    wait_st(`ST_TX_EMPTY);
    check(rdat[`ST_TX_EMPTY], 1'h1, "char completed");
    clear_to_send_low <= 1'h0;
    apb(1'h1, `OFS_COMMAND, 8'h08);
  endtask
  task automatic test_rts();
    set_mode(8'h13, 8'h27);
    apb(1'h1, `OFS_COMMAND, 8'h84);
    check(request_to_send_low, 1'h0, "rts asserted");
    fork
      begin
        wait (tx_data_out === 1'h0);
        for (cyc = 0; cyc < 2000 && request_to_send_low !== 1'h1; cyc++)
          @(posedge pclk);
      end
      begin
        apb(1'h1, `OFS_DATA, 8'h55);
        apb(1'h1, `OFS_COMMAND, 8'h08);
      end
    join
    check(cyc inside {[704:711]}, 1'h1, "auto rts negate time");
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tdiv} = '0;
    {tx_tick, tx_ext_1x, rx_tick16, clear_to_send_low} = '0;
    {err_count, tests_run, cycles, cyc} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    test_regs();
    test_stop();
    test_echo();
    test_local();
    test_cts();
    test_rts();
    give_verdict();
  end
endmodule
bind uart_chan uart_chan_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_tick(tx_tick), .tx_ext_1x(tx_ext_1x),
  .rx_tick16(rx_tick16), .rx_data_in(rx_data_in), .tx_data_out(tx_data_out),
  .clear_to_send_low(clear_to_send_low), .request_to_send_low(request_to_send_low));
